// ==== hw/pesr_pkg.sv ====
/*
 * Package for the transceiver event and status register pair.
 * Assumes a management serial interface front end that decodes frames into
 * register number, read and write strobes and write data.
 */
package pesr_pkg;

	// ---------------------------------------------------------------
	// Register numbers
	// ---------------------------------------------------------------
	localparam logic [4:0] PESR_VENDOR_FIRST = 5'h10;
	localparam logic [4:0] PESR_VENDOR_LAST  = 5'h1d;
	localparam logic [4:0] PESR_REG_EVENT    = 5'h10;
	localparam logic [4:0] PESR_REG_STATUS   = 5'h11;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int PESR_EN_LSB       = 8;
	localparam int PESR_NUM_EVENTS   = 7;
	localparam int PESR_ST_LINK_DOWN = 14;
	localparam int PESR_ST_DUPLEX    = 13;
	localparam int PESR_ST_SPEED     = 12;
	localparam int PESR_ST_NEG_DONE  = 10;
	localparam int PESR_ST_PAGE_STBL = 9;
	localparam int PESR_ST_NO_COMMON = 8;
	localparam int PESR_ST_POL_REV   = 5;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [6:0]  PESR_EN_RESET   = 7'h00;
	localparam logic [6:0]  PESR_FLAG_RESET = 7'h00;
	localparam logic [15:0] PESR_RD_RESET   = 16'h0000;

	// Event vector, bit order matches flag bits 6..0.
	typedef struct packed {
		logic ack_rx;
		logic page_rx;
		logic link_change;
		logic negotiation_change;
		logic parallel_fault;
		logic remote_fault;
		logic jabber;
	} pesr_event_s;

	// Line state sampled from the transceiver core.
	typedef struct packed {
		logic std_link_state_bit;
		logic duplex_full;
		logic speed_100;
		logic std_negotiation_done_bit;
		logic page_stable;
		logic no_common_mode;
		logic polarity_reversed;
	} pesr_line_s;

	// Management access as decoded by the serial front end.
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [4:0]  regnum;
		logic [15:0] wdata;
	} pesr_mgmt_s;

endpackage

// ==== hw/pesr_regs.sv ====
/*
 * Event enable/flag register and vendor link status register.
 * Assumes the management front end gives one-cycle rd/wr strobes and samples
 * rdata_out the cycle after rd; all inputs are synchronous to sys_clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
// Function
// - Vendor registers at numbers 16 to 29
// - Bit 14 enables acknowledge event interrupt
// - Bit 13 enables page received interrupt
// - Bit 12 enables link change interrupt
// - Bit 11 enables negotiation change interrupt
// - Bit 10 enables parallel fault interrupt
// - Bit 9 enables remote fault interrupt
// - Bit 8 enables jabber interrupt
// - Flag 6 latches acknowledge, clears on access
// - Flag 5 latches new page, clears on access
// - Flag 4 latches link change, clears on access
// - Flag 3 latches negotiation change, clears on access
// - Flag 2 set by parallel fault rise
// - Flag 1 set by remote fault rise
// - Flag 0 set by jabber rise
// - Status 14 inverts link bit, 1 down
// - Status 13 shows duplex, 1 full
// - Status 12 shows speed, 1 100M
// - Status 10 mirrors negotiation complete bit
// - Status 9 shows three identical words
// - Status 8 shows no common mode
// - Status 5 shows receive polarity reversed
module pesr_regs
	import pesr_pkg::*;
(
	input  wire logic        sys_clk_in,   // 100 MHz clock
	input  wire logic        rst_n_in,     // async reset, active low
	input  wire pesr_mgmt_s  mgmt_in,      // decoded management access
	input  wire pesr_event_s event_in,     // event levels from core
	input  wire pesr_line_s  line_in,      // line state from core
	output var  logic [15:0] rdata_out,    // read data, valid after rd
	output var  logic        rvalid_out,   // read data strobe
	output var  logic        irq_out       // event interrupt, active high
);

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	function automatic logic is_reg(input logic [4:0] num, input logic [4:0] want);
		is_reg = (num == want);
	endfunction

	logic       ev_access;
	logic [6:0] ev_now;
	logic [6:0] ev_prev;
	logic [6:0] ev_rise;
	logic [6:0] event_en;
	logic [6:0] event_flag;
	logic [6:0] next_flag;
	logic       link_prev;
	logic       link_toggle;
	logic       link_armed;
	logic       ev_write;
	logic       st_read;
	logic [6:0] next_en;

	assign ev_access = (mgmt_in.rd | mgmt_in.wr) & is_reg(mgmt_in.regnum, PESR_REG_EVENT);
	assign ev_write  = mgmt_in.wr & is_reg(mgmt_in.regnum, PESR_REG_EVENT);
	assign st_read   = mgmt_in.rd & is_reg(mgmt_in.regnum, PESR_REG_STATUS);
	assign ev_now    = event_in;

	// ---------------------------------------------------------------
	// Event detection
	// ---------------------------------------------------------------
	// Edge detection keeps a fault that stays high from re-arming the flag
	// after every read.
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ev_prev    <= PESR_FLAG_RESET;
			link_prev  <= 1'b0;
			link_armed <= 1'b0;
		end
		else
		begin
			ev_prev    <= ev_now;
			link_prev  <= line_in.std_link_state_bit;
			link_armed <= 1'b1;
		end
	end

	// The link level before reset is unknown, so the first edge after reset
	// only records it; otherwise a link that is up would look like a change.
	assign link_toggle = link_armed & (line_in.std_link_state_bit ^ link_prev);
	// Flags 6..3 follow their event strobes; 2..0 take rising edges only.
	assign ev_rise = {ev_now[6:5], ev_now[4] | link_toggle, ev_now[3],
			  ev_now[2:0] & ~ev_prev[2:0]};

	// ---------------------------------------------------------------
	// Enables and sticky flags
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			event_en <= PESR_EN_RESET;
		else
			event_en <= next_en;
	end

	// The interrupt is built from the enables as they stand after this edge,
	// so a write that masks a pending flag drops the interrupt at once.
	always_comb
	begin
		next_en = event_en;
		if (ev_write)
			next_en = mgmt_in.wdata[PESR_EN_LSB +: PESR_NUM_EVENTS];
	end

	// Any access to the event register clears; a new event in the same cycle survives the clear.
	always_comb
	begin
		next_flag = ev_access ? PESR_FLAG_RESET : event_flag;
		next_flag = next_flag | ev_rise;
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			event_flag <= PESR_FLAG_RESET;
		else
			event_flag <= next_flag;
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			irq_out <= 1'b0;
		else
			irq_out <= |(next_flag & next_en);
	end

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	// Registers 16 to 29 other than the two built here read as zero.
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rdata_out  <= PESR_RD_RESET;
			rvalid_out <= 1'b0;
		end
		else
		begin
			rvalid_out <= mgmt_in.rd;
			if (mgmt_in.rd)
			begin
				rdata_out <= PESR_RD_RESET;
				if (is_reg(mgmt_in.regnum, PESR_REG_EVENT))
				begin
					rdata_out[PESR_EN_LSB +: PESR_NUM_EVENTS] <= event_en;
					rdata_out[PESR_NUM_EVENTS-1:0]            <= event_flag;
				end
				else if (is_reg(mgmt_in.regnum, PESR_REG_STATUS))
				begin
					rdata_out[PESR_ST_LINK_DOWN] <= ~line_in.std_link_state_bit;
					rdata_out[PESR_ST_DUPLEX]    <= line_in.duplex_full;
					rdata_out[PESR_ST_SPEED]     <= line_in.speed_100;
					rdata_out[PESR_ST_NEG_DONE]  <= line_in.std_negotiation_done_bit;
					rdata_out[PESR_ST_PAGE_STBL] <= line_in.page_stable;
					rdata_out[PESR_ST_NO_COMMON] <= line_in.no_common_mode;
					rdata_out[PESR_ST_POL_REV]   <= line_in.polarity_reversed;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_reg_window: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(PESR_REG_EVENT >= PESR_VENDOR_FIRST) && (PESR_REG_EVENT <= PESR_VENDOR_LAST)
		&& (PESR_REG_STATUS >= PESR_VENDOR_FIRST) && (PESR_REG_STATUS <= PESR_VENDOR_LAST))
		else $error("register numbers outside vendor range");

	a_jabber_rise: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		event_in.jabber && !$past(event_in.jabber) |=> event_flag[0])
		else $error("jabber rise not latched");

	a_remote_rise: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		event_in.remote_fault && !$past(event_in.remote_fault) |=> event_flag[1])
		else $error("remote fault rise not latched");

	a_pfault_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		event_flag[2] && !ev_access |=> event_flag[2])
		else $error("parallel fault flag dropped without access");

	a_access_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ev_access && !event_in.ack_rx |=> !event_flag[6])
		else $error("ack flag not cleared by access");

	a_page_latch: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		event_in.page_rx |=> event_flag[5])
		else $error("page flag not set");

	a_link_change: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		link_armed && $changed(line_in.std_link_state_bit) |=> event_flag[4])
		else $error("link change not latched");

	a_neg_change: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		event_in.negotiation_change |=> event_flag[3])
		else $error("negotiation change not latched");

	a_irq_gate: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		irq_out == |(event_flag & event_en))
		else $error("interrupt disagrees with enabled flags");

	a_link_read: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		mgmt_in.rd && is_reg(mgmt_in.regnum, PESR_REG_STATUS)
		|=> rdata_out[PESR_ST_LINK_DOWN] == !$past(line_in.std_link_state_bit))
		else $error("link down bit wrong");

	a_ack_enable: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ev_write |=> event_en[6] == $past(mgmt_in.wdata[PESR_EN_LSB + 6]))
		else $error("acknowledge enable not written");

	a_page_enable: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ev_write |=> event_en[5] == $past(mgmt_in.wdata[PESR_EN_LSB + 5]))
		else $error("page enable not written");

	a_link_enable: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ev_write |=> event_en[4] == $past(mgmt_in.wdata[PESR_EN_LSB + 4]))
		else $error("link change enable not written");

	a_neg_enable: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ev_write |=> event_en[3] == $past(mgmt_in.wdata[PESR_EN_LSB + 3]))
		else $error("negotiation enable not written");

	a_pfault_enable: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ev_write |=> event_en[2] == $past(mgmt_in.wdata[PESR_EN_LSB + 2]))
		else $error("parallel fault enable not written");

	a_remote_enable: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ev_write |=> event_en[1] == $past(mgmt_in.wdata[PESR_EN_LSB + 1]))
		else $error("remote fault enable not written");

	a_jabber_enable: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ev_write |=> event_en[0] == $past(mgmt_in.wdata[PESR_EN_LSB]))
		else $error("jabber enable not written");

	a_enable_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		!ev_write |=> $stable(event_en))
		else $error("enables changed without a write");

	a_irq_masked: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(event_flag & event_en) == 7'h00 |-> !irq_out)
		else $error("interrupt raised with no enabled flag");

	a_irq_raise: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(event_flag & event_en) != 7'h00 |-> irq_out)
		else $error("interrupt missing for an enabled flag");

	a_ack_latch: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		event_in.ack_rx |=> event_flag[6])
		else $error("ack flag not set");

	a_ack_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		event_flag[6] && !ev_access |=> event_flag[6])
		else $error("ack flag dropped without access");

	a_page_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		event_flag[5] && !ev_access |=> event_flag[5])
		else $error("page flag dropped without access");

	a_page_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ev_access && !event_in.page_rx |=> !event_flag[5])
		else $error("page flag not cleared by access");

	a_link_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		event_flag[4] && !ev_access |=> event_flag[4])
		else $error("link change flag dropped without access");

	a_neg_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		event_flag[3] && !ev_access |=> event_flag[3])
		else $error("negotiation flag dropped without access");

	a_neg_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ev_access && !event_in.negotiation_change |=> !event_flag[3])
		else $error("negotiation flag not cleared by access");

	a_pfault_rise: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		event_in.parallel_fault && !$past(event_in.parallel_fault) |=> event_flag[2])
		else $error("parallel fault rise not latched");

	a_remote_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		event_flag[1] && !ev_access |=> event_flag[1])
		else $error("remote fault flag dropped without access");

	a_remote_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ev_access && !event_in.remote_fault |=> !event_flag[1])
		else $error("remote fault flag not cleared by access");

	a_jabber_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		event_flag[0] && !ev_access |=> event_flag[0])
		else $error("jabber flag dropped without access");

	a_jabber_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ev_access && !event_in.jabber |=> !event_flag[0])
		else $error("jabber flag not cleared by access");

	a_flags_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ev_access && ev_now == 7'h00 && $stable(line_in.std_link_state_bit)
		|=> event_flag == PESR_FLAG_RESET)
		else $error("flags not cleared by a quiet access");

	a_event_read: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ev_access && mgmt_in.rd |=> rdata_out == {1'b0, $past(event_en), 1'b0, $past(event_flag)})
		else $error("event register read back wrong");

	a_duplex_read: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		st_read |=> rdata_out[PESR_ST_DUPLEX] == $past(line_in.duplex_full))
		else $error("duplex bit wrong");

	a_speed_read: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		st_read |=> rdata_out[PESR_ST_SPEED] == $past(line_in.speed_100))
		else $error("speed bit wrong");

	a_negdone_read: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		st_read |=> rdata_out[PESR_ST_NEG_DONE] == $past(line_in.std_negotiation_done_bit))
		else $error("negotiation done bit wrong");

	a_page_read: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		st_read |=> rdata_out[PESR_ST_PAGE_STBL] == $past(line_in.page_stable))
		else $error("page stable bit wrong");

	a_nocommon_read: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		st_read |=> rdata_out[PESR_ST_NO_COMMON] == $past(line_in.no_common_mode))
		else $error("no common mode bit wrong");

	a_polarity_read: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		st_read |=> rdata_out[PESR_ST_POL_REV] == $past(line_in.polarity_reversed))
		else $error("polarity bit wrong");

	a_other_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		mgmt_in.rd && !ev_access && !st_read |=> rdata_out == PESR_RD_RESET)
		else $error("unused register number did not read zero");

	a_read_strobe: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		mgmt_in.rd |=> rvalid_out)
		else $error("read strobe missing");

	a_strobe_idle: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		!mgmt_in.rd |=> !rvalid_out)
		else $error("read strobe without a read");

endmodule
`default_nettype wire

// ==== test/pesr_sta.sv ====
/*
 * Station management model that issues one-cycle register accesses.
 * Assumes the block samples requests on the rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module pesr_sta
	import pesr_pkg::*;
(
	input  wire logic       clk_in,   // bench clock
	output var  pesr_mgmt_s mgmt_out  // access to the block
);
	initial mgmt_out = '0;

	// Idle fields carry the inverse of the last request, so stale values never pass.
	task automatic access(input logic w, input logic [4:0] r, input logic [15:0] d);
		@(posedge clk_in);
		mgmt_out <= '{rd: !w, wr: w, regnum: r, wdata: d};
		@(posedge clk_in);
		mgmt_out <= '{rd: 1'b0, wr: 1'b0, regnum: ~r, wdata: ~d};
	endtask
endmodule
`default_nettype wire

// ==== test/tb_phy_event_and_status_regs.sv ====
/*
 * Self-checking bench for the event and status register pair.
 * Assumes pesr_pkg and the station management model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_phy_event_and_status_regs;
	import pesr_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rst_n   = 1'b0;
	pesr_mgmt_s  mgmt;
	pesr_event_s ev      = '0;
	pesr_line_s  line    = '0;
	logic [15:0] rdata;
	logic        rvalid;
	logic        irq;
	logic [15:0] exp_q[$];
	int          errors    = 0;
	int          cmp_count = 0;
	logic [31:0] rnd       = 32'h7b28;
	logic [6:0]  en;

	always #5 sys_clk = ~sys_clk;

	pesr_sta sta (.clk_in(sys_clk), .mgmt_out(mgmt));

	pesr_regs dut (
		.sys_clk_in(sys_clk),
		.rst_n_in  (rst_n),
		.mgmt_in   (mgmt),
		.event_in  (ev),
		.line_in   (line),
		.rdata_out (rdata),
		.rvalid_out(rvalid),
		.irq_out   (irq)
	);

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic check(input string what, input logic [15:0] e, input logic [15:0] s);
		cmp_count++;
		if (e !== s)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, e, s);
		end
	endtask

	// Reads queue their expectation; the watcher below pairs it with the answer.
	task automatic rd(input logic [4:0] r, input logic [15:0] e);
		exp_q.push_back(e);
		sta.access(1'b0, r, 16'h0000);
	endtask

	always @(posedge sys_clk)
	begin
		if (rvalid === 1'b1)
		begin
			if (exp_q.size() == 0)
				check("unrequested rvalid", 16'h0000, 16'h0001);
			else
				check("rdata", exp_q.pop_front(), rdata);
		end
	end

	task automatic results();
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial
	begin
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		rnd = lfsr(rnd);
		line <= rnd[6:0];
		repeat (3) @(posedge sys_clk);
		rd(PESR_REG_STATUS, {1'b0, ~line.std_link_state_bit, line.duplex_full, line.speed_100,
			1'b0, line.std_negotiation_done_bit, line.page_stable, line.no_common_mode, 2'b00,
			line.polarity_reversed, 5'h00});
		rd(5'h05, 16'h0000);
		// Second pass inverts the enables so every event is seen masked and unmasked.
		for (int p = 0; p < 2; p++)
		begin
			rnd = lfsr(rnd);
			en = (p == 0) ? rnd[14:8] : ~en;
			sta.access(1'b1, PESR_REG_EVENT, {rnd[15], en, rnd[7:0]});
			rd(PESR_REG_EVENT, {1'b0, en, 8'h00});
			for (int i = 0; i < PESR_NUM_EVENTS; i++)
			begin
				@(posedge sys_clk) ev <= pesr_event_s'(7'h01 << i);
				@(posedge sys_clk) ev <= '0;
				@(posedge sys_clk);
				@(negedge sys_clk) check("irq", {15'h0000, en[i]}, {15'h0000, irq});
				rd(PESR_REG_EVENT, {1'b0, en, 1'b0, 7'h01 << i});
				rd(PESR_REG_EVENT, {1'b0, en, 8'h00});
			end
		end
		// A mid-run reset must drop enables, flags and the interrupt together.
		sta.access(1'b1, PESR_REG_EVENT, {1'b0, 7'h7f, 8'h00});
		@(posedge sys_clk) ev <= pesr_event_s'(7'h7f);
		@(posedge sys_clk) ev <= '0;
		@(negedge sys_clk) check("irq armed", 16'h0001, {15'h0000, irq});
		@(posedge sys_clk) rst_n <= 1'b0;
		@(negedge sys_clk) check("irq in reset", 16'h0000, {15'h0000, irq});
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(PESR_REG_EVENT, 16'h0000);
		rd(PESR_VENDOR_LAST, 16'h0000);
		for (int i = 0; i < 20 && exp_q.size() > 0; i++)
			@(posedge sys_clk);
		if (exp_q.size() > 0)
		begin
			errors++;
			$display("mismatch pending reads expected 0 seen %0d", exp_q.size());
		end
		results();
	end
endmodule
`default_nettype wire
